// [test_clock_system_fll_and_fault.sv]
// Bench for the clock system block: tables of select, power and loop cases.
// Assumes the design files and the constants header are compiled before it.
`timescale 1ns/1ns
`default_nettype none
`include "ucsfll_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_clock_system_fll_and_fault;
    logic clk = 1'b0, resetn = 1'b0, ref_clk_pin = 1'b0, osc_tick = 1'b1, sel_write = 1'b0;
    logic low_power_level_zero = 1'b0, low_power_level_two_up = 1'b0, sysclk_gen1_off = 1'b0;
    logic low_power_level_four = 1'b0, crystal_one_bypass_bit = 1'b0, crystal_one_hf_mode = 1'b0;
    logic crystal_two_bypass_on = 1'b0, crystal_input_one_ok = 1'b1, crystal_input_two_ok = 1'b1;
    logic osc_fault_in = 1'b0, fault_clear = 1'b0, osc_fault_irq_en = 1'b0;
    logic [`UCSFLL_CNT_W-1:0] loop_multiplier = 16'h0020;
    logic [2:0] main_clk_source_sel = 3'h3, sub_clk_source_sel = 3'h3, aux_clk_source_sel = 3'h0;
    logic [4:0] osc_tap_field, osc_modulation_field;
    logic [2:0] main_clk_route, sub_clk_route, aux_clk_route;
    logic crystal_one_fault_flag, crystal_two_fault_flag, osc_fault_flag, nmi_req;
    logic power_manager_low_current, loop_enabled;
    int bad_count = 0, n_checks = 0;
    // Rows: {main, sub, aux, crystal one ok, irq enable, fault expected}
    logic [11:0] sel_rows [5] = '{12'h0C3, 12'h0C2, 12'h606, 12'h6C1, 12'h604};
    // Rows: {low_power_level_four, bypass, hf mode, crystal two on, low current expected}
    logic [4:0] pwr_rows [4] = '{5'h1C, 5'h15, 5'h12, 5'h00};
    // Rows: {low_power_level_zero, lpm2 up, gen1 off, loop expected}; last row leaves loop running
    logic [3:0] lp_rows [5] = '{4'h8, 4'h6, 4'h5, 4'h3, 4'h1};

    ucsfll_top uut (.clk, .resetn, .ref_clk_pin, .osc_tick, .loop_multiplier,
        .low_power_level_zero, .low_power_level_two_up, .low_power_level_four,
        .sysclk_gen1_off, .crystal_one_bypass_bit, .crystal_one_hf_mode,
        .crystal_two_bypass_on, .sel_write, .main_clk_source_sel, .sub_clk_source_sel,
        .aux_clk_source_sel, .crystal_input_one_ok, .crystal_input_two_ok, .osc_fault_in,
        .fault_clear, .osc_fault_irq_en, .osc_tap_field, .osc_modulation_field,
        .main_clk_route, .sub_clk_route, .aux_clk_route, .crystal_one_fault_flag,
        .crystal_two_fault_flag, .osc_fault_flag, .nmi_req, .power_manager_low_current,
        .loop_enabled);

    always #20 clk = ~clk;

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Reference of 40 clocks a period; ticks every clock, so a count of 39 beats 32
    task automatic ref_periods(input int n);
        repeat (n) begin
            ref_clk_pin = 1'b1;
            step(20);
            ref_clk_pin = 1'b0;
            step(20);
        end
    endtask

    task automatic give_verdict;
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        step(10);
        resetn = 1'b1;
        step(1);
        `CHK("trim", 10'h1E0, {osc_tap_field, osc_modulation_field})
        `CHK("route", 9'h0D8, {main_clk_route, sub_clk_route, aux_clk_route})
        `CHK("flags", 2'h0, {crystal_one_fault_flag, crystal_two_fault_flag})
        `CHK("flags_any", 2'h0, {osc_fault_flag, nmi_req})
        foreach (sel_rows[i]) begin
            {main_clk_source_sel, sub_clk_source_sel, aux_clk_source_sel,
                crystal_input_one_ok, osc_fault_irq_en} = sel_rows[i][11:1];
            sel_write = 1'b1;
            step(1);
            sel_write = 1'b0;
            `CHK("route", sel_rows[i][11:3], {main_clk_route, sub_clk_route, aux_clk_route})
            `CHK("cry1", sel_rows[i][0], crystal_one_fault_flag)
            `CHK("any", sel_rows[i][0], osc_fault_flag)
            `CHK("nmi", sel_rows[i][0] & sel_rows[i][1], nmi_req)
            step(3);
            `CHK("sticky", sel_rows[i][0], osc_fault_flag)
            fault_clear = 1'b1;
            step(1);
            fault_clear = 1'b0;
            `CHK("clear", 3'h0, {crystal_one_fault_flag, osc_fault_flag, nmi_req})
        end
        osc_fault_in = 1'b1;
        step(1);
        osc_fault_in = 1'b0;
        step(1);
        `CHK("osc", 1'b1, osc_fault_flag)
        `CHK("osc_only", 2'h0, {crystal_one_fault_flag, crystal_two_fault_flag})
        // Clear and a second-crystal fault in one cycle: the set must win
        crystal_input_two_ok = 1'b0;
        main_clk_source_sel = `UCSFLL_SRC_CRY2;
        sel_write = 1'b1;
        fault_clear = 1'b1;
        step(1);
        {sel_write, fault_clear, crystal_input_two_ok} = 3'h1;
        step(2);
        `CHK("cry2", 2'h1, {crystal_one_fault_flag, crystal_two_fault_flag})
        `CHK("cry2_any", 1'b1, osc_fault_flag)
        `CHK("cry2_route", `UCSFLL_SRC_CRY2, main_clk_route)
        fault_clear = 1'b1;
        step(1);
        fault_clear = 1'b0;
        `CHK("clear_all", 2'h0, {crystal_two_fault_flag, osc_fault_flag})
        foreach (pwr_rows[i]) begin
            {low_power_level_four, crystal_one_bypass_bit, crystal_one_hf_mode,
                crystal_two_bypass_on} = pwr_rows[i][4:1];
            step(2);
            `CHK("low_current", pwr_rows[i][0], power_manager_low_current)
        end
        foreach (lp_rows[i]) begin
            {low_power_level_zero, low_power_level_two_up, sysclk_gen1_off} = lp_rows[i][3:1];
            step(2);
            `CHK("loop_on", lp_rows[i][0], loop_enabled)
        end
        // Two edges only capture; the trim must not move yet
        ref_periods(2);
        `CHK("trim_hold", 10'h1E0, {osc_tap_field, osc_modulation_field})
        ref_periods(1);
        `CHK("trim_step", 10'h1DF, {osc_tap_field, osc_modulation_field})
        resetn = 1'b0;
        step(1);
        resetn = 1'b1;
        step(1);
        `CHK("trim_rst", 10'h1E0, {osc_tap_field, osc_modulation_field})
        `CHK("route_rst", 9'h0D8, {main_clk_route, sub_clk_route, aux_clk_route})
        // Target above the measured count of 39: the trim steps up
        loop_multiplier = 16'h0030;
        ref_periods(3);
        `CHK("trim_up", 10'h1E1, {osc_tap_field, osc_modulation_field})
        // A short hold-off re-arms from scratch, so two edges leave the trim alone
        {low_power_level_two_up, sysclk_gen1_off} = 2'h3;
        step(2);
        `CHK("held", 1'b0, loop_enabled)
        {low_power_level_two_up, sysclk_gen1_off} = 2'h0;
        ref_periods(2);
        `CHK("rearm", 10'h1E1, {osc_tap_field, osc_modulation_field})
        give_verdict();
    end

    // Whole run is well under a thousand clocks; this only catches a hang
    initial begin
        #(40 * 5000);
        bad_count++;
        give_verdict();
    end
endmodule
`undef CHK
`default_nettype wire

// [ucsfll_pkg.sv]
// Types of the clock system block.
// Assumes the constants header is on the include path.
`include "ucsfll_regs.svh"
package ucsfll_pkg;
    typedef enum logic [1:0] {
        UCSFLL_IDLE = 2'b00,
        UCSFLL_ARM = 2'b01,
        UCSFLL_CAPT = 2'b10,
        UCSFLL_APPLY = 2'b11
    } ucsfll_state_t;
    typedef struct packed {
        logic [2:0] ref_sync;
        ucsfll_state_t fsm;
        logic [`UCSFLL_CNT_W-1:0] count;
        logic [`UCSFLL_CNT_W-1:0] measured;
        logic [`UCSFLL_TAP_W-1:0] tap;
        logic [`UCSFLL_MOD_W-1:0] modu;
        logic [`UCSFLL_SEL_W-1:0] sel_m;
        logic [`UCSFLL_SEL_W-1:0] sel_s;
        logic [`UCSFLL_SEL_W-1:0] sel_a;
        logic cry1_fault;
        logic cry2_fault;
        logic osc_fault;
        logic fault_any;
        logic nmi;
        logic low_current;
        logic loop_on;
    } ucsfll_state_s_t;
endpackage

// [ucsfll_regs.svh]
// Constants of the clock system: loop timing, source codes, field widths.
// Assumes inclusion by its bare name from the package and the design file.
`ifndef UCSFLL_REGS_SVH
`define UCSFLL_REGS_SVH
`define UCSFLL_TAP_W 5
`define UCSFLL_MOD_W 5
`define UCSFLL_CNT_W 16
`define UCSFLL_SEL_W 3
`define UCSFLL_TAP_RST 5'h0F
`define UCSFLL_MOD_RST 5'h00
`define UCSFLL_MULT_RST 16'h0020
`define UCSFLL_SRC_CRY1 3'h0
`define UCSFLL_SRC_OSC 3'h3
`define UCSFLL_SRC_CRY2 3'h5
`define UCSFLL_CAPTURE_PERIODS 2'h2
`define UCSFLL_APPLY_PERIODS 2'h1
`endif

// [ucsfll_top.sv]
// Clock system: frequency lock loop, source selection, fault flags, deep-sleep gate.
// Assumes oscillator ticks arrive as same-clock pulses; reference is a pin.
`timescale 1ns/1ns
`default_nettype none
`include "ucsfll_regs.svh"
module ucsfll_top (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ref_clk_pin,
    input wire logic osc_tick,
    input wire logic [`UCSFLL_CNT_W-1:0] loop_multiplier,
    input wire logic low_power_level_zero,
    input wire logic low_power_level_two_up,
    input wire logic low_power_level_four,
    input wire logic sysclk_gen1_off,
    input wire logic crystal_one_bypass_bit,
    input wire logic crystal_one_hf_mode,
    input wire logic crystal_two_bypass_on,
    input wire logic sel_write,
    input wire logic [`UCSFLL_SEL_W-1:0] main_clk_source_sel,
    input wire logic [`UCSFLL_SEL_W-1:0] sub_clk_source_sel,
    input wire logic [`UCSFLL_SEL_W-1:0] aux_clk_source_sel,
    input wire logic crystal_input_one_ok,
    input wire logic crystal_input_two_ok,
    input wire logic osc_fault_in,
    input wire logic fault_clear,
    input wire logic osc_fault_irq_en,
    output logic [`UCSFLL_TAP_W-1:0] osc_tap_field,
    output logic [`UCSFLL_MOD_W-1:0] osc_modulation_field,
    output logic [`UCSFLL_SEL_W-1:0] main_clk_route,
    output logic [`UCSFLL_SEL_W-1:0] sub_clk_route,
    output logic [`UCSFLL_SEL_W-1:0] aux_clk_route,
    output logic crystal_one_fault_flag,
    output logic crystal_two_fault_flag,
    output logic osc_fault_flag,
    output logic nmi_req,
    output logic power_manager_low_current,
    output logic loop_enabled
);
    import ucsfll_pkg::*;

    ucsfll_state_s_t r;
    ucsfll_state_s_t next_r;
    logic ref_rise;
    logic osc_used;
    logic loop_allow;
    logic sel_changed;
    logic bypass_busy;
    logic [`UCSFLL_TAP_W+`UCSFLL_MOD_W-1:0] trim;

    always_comb begin
        // Bit 0 is the first synchroniser stage; bits 1 and 2 feed the edge detect
        ref_rise = r.ref_sync[1] & ~r.ref_sync[2];
        osc_used = (r.sel_a == `UCSFLL_SRC_OSC) || (r.sel_s == `UCSFLL_SRC_OSC);
        loop_allow = ~((low_power_level_zero & ~osc_used) |
            (low_power_level_two_up & sysclk_gen1_off));
        sel_changed = sel_write & ((main_clk_source_sel != r.sel_m) |
            (sub_clk_source_sel != r.sel_s) | (aux_clk_source_sel != r.sel_a));
        // Bit low means bypass off
        bypass_busy = (crystal_one_bypass_bit & crystal_one_hf_mode) | crystal_two_bypass_on;
        trim = {r.tap, r.modu};
        next_r = r;
        next_r.ref_sync = {r.ref_sync[1:0], ref_clk_pin};
        next_r.loop_on = loop_allow;
        case (r.fsm)
            UCSFLL_IDLE: begin
                // No settle delay on enable, so short bursts drift
                if (loop_allow) begin
                    next_r.fsm = UCSFLL_ARM;
                end
            end
            UCSFLL_ARM: begin
                next_r.count = '0;
                if (ref_rise) begin
                    next_r.fsm = UCSFLL_CAPT;
                end
            end
            UCSFLL_CAPT: begin
                if (osc_tick) begin
                    next_r.count = r.count + 16'h0001;
                end
                if (ref_rise) begin
                    next_r.measured = r.count;
                    next_r.fsm = UCSFLL_APPLY;
                end
            end
            UCSFLL_APPLY: begin
                // Apply in the period after the capture
                // Saturate, so a lost reference cannot wrap the trim
                if (ref_rise) begin
                    if (r.measured < loop_multiplier && trim != '1) begin
                        trim = trim + 10'h001;
                    end else if (r.measured > loop_multiplier && trim != '0) begin
                        trim = trim - 10'h001;
                    end
                    next_r.tap = trim[`UCSFLL_TAP_W+`UCSFLL_MOD_W-1:`UCSFLL_MOD_W];
                    next_r.modu = trim[`UCSFLL_MOD_W-1:0];
                    next_r.count = '0;
                    next_r.fsm = UCSFLL_CAPT;
                end
            end
            default: begin
                next_r.fsm = UCSFLL_IDLE;
            end
        endcase
        if (!loop_allow) begin
            next_r.fsm = UCSFLL_IDLE;
        end
        if (sel_write) begin
            next_r.sel_m = main_clk_source_sel;
            next_r.sel_s = sub_clk_source_sel;
            next_r.sel_a = aux_clk_source_sel;
        end
        // Clear first and set after it, so an event in the clear cycle is kept
        if (fault_clear) begin
            next_r.cry1_fault = 1'b0;
            next_r.cry2_fault = 1'b0;
            next_r.osc_fault = 1'b0;
        end
        // Spurious request on any select change while that crystal input is not ok
        if (sel_changed & ~crystal_input_one_ok) begin
            next_r.cry1_fault = 1'b1;
        end
        if (sel_changed & ~crystal_input_two_ok) begin
            next_r.cry2_fault = 1'b1;
        end
        if (osc_fault_in) begin
            next_r.osc_fault = 1'b1;
        end
        next_r.fault_any = next_r.cry1_fault | next_r.cry2_fault |
            next_r.osc_fault;
        // Request follows the flag in the same cycle, not one later
        next_r.nmi = next_r.fault_any & osc_fault_irq_en;
        // Registered, so the power manager never sees a glitch
        next_r.low_current = low_power_level_four & ~bypass_busy;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            r <= '0;
            r.tap <= `UCSFLL_TAP_RST;
            r.modu <= `UCSFLL_MOD_RST;
            r.sel_m <= `UCSFLL_SRC_OSC;
            r.sel_s <= `UCSFLL_SRC_OSC;
            r.sel_a <= `UCSFLL_SRC_CRY1;
            r.fsm <= UCSFLL_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign osc_tap_field = r.tap;
    assign osc_modulation_field = r.modu;
    assign main_clk_route = r.sel_m;
    assign sub_clk_route = r.sel_s;
    assign aux_clk_route = r.sel_a;
    assign crystal_one_fault_flag = r.cry1_fault;
    assign crystal_two_fault_flag = r.cry2_fault;
    assign osc_fault_flag = r.fault_any;
    assign nmi_req = r.nmi;
    assign power_manager_low_current = r.low_current;
    assign loop_enabled = r.loop_on;

    a_loop_held_off: assert property (@(posedge clk) disable iff (!resetn)
        (low_power_level_two_up & sysclk_gen1_off) |=> (r.fsm == UCSFLL_IDLE && !loop_enabled))
        else $error("loop ran while held off");
    a_light_sleep_hold: assert property (@(posedge clk) disable iff (!resetn)
        (low_power_level_zero && !osc_used) |=> !loop_enabled)
        else $error("loop ran in light sleep with oscillator unused");
    // Reset reloads the trim, so the edge after a reset is no apply step
    a_trim_only_apply: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) && ($changed(osc_tap_field) || $changed(osc_modulation_field)) |->
        $past(r.fsm) == UCSFLL_APPLY)
        else $error("trim changed outside apply");
    a_trim_one_step: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) && $changed({r.tap, r.modu}) |->
        ({r.tap, r.modu} == $past({r.tap, r.modu}) + 10'h001) ||
        ({r.tap, r.modu} == $past({r.tap, r.modu}) - 10'h001))
        else $error("trim moved by more than one step");
    a_capture_on_edge: assert property (@(posedge clk) disable iff (!resetn)
        (r.fsm == UCSFLL_ARM && ref_rise && loop_allow) |=> r.fsm == UCSFLL_CAPT && r.count == 0)
        else $error("capture did not start on reference edge");
    a_enable_at_once: assert property (@(posedge clk) disable iff (!resetn)
        (r.fsm == UCSFLL_IDLE && loop_allow) |=> r.fsm == UCSFLL_ARM)
        else $error("loop did not start at once");
    a_deep_bypass: assert property (@(posedge clk) disable iff (!resetn)
        (crystal_two_bypass_on) |=> !power_manager_low_current)
        else $error("low current while bypass active");
    a_bypass_one: assert property (@(posedge clk) disable iff (!resetn)
        (crystal_one_bypass_bit & crystal_one_hf_mode) |=> !power_manager_low_current)
        else $error("low current while first crystal bypass active");
    a_deep_gate: assert property (@(posedge clk) disable iff (!resetn)
        power_manager_low_current |-> $past(low_power_level_four))
        else $error("low current without deep sleep request");
    a_bypass_off: assert property (@(posedge clk) disable iff (!resetn)
        (low_power_level_four & ~crystal_one_bypass_bit & ~crystal_two_bypass_on)
        |=> power_manager_low_current)
        else $error("low current refused with bypass off");
    a_sel_fault: assert property (@(posedge clk) disable iff (!resetn)
        (sel_changed & ~crystal_input_one_ok) |=>
        crystal_one_fault_flag && (nmi_req || !$past(osc_fault_irq_en)))
        else $error("select change did not flag absent crystal");
    a_two_fault: assert property (@(posedge clk) disable iff (!resetn)
        (sel_changed & ~crystal_input_two_ok) |=> crystal_two_fault_flag)
        else $error("select change did not flag absent second crystal");
    a_route_follow: assert property (@(posedge clk) disable iff (!resetn)
        sel_write |=> main_clk_route == $past(main_clk_source_sel))
        else $error("main clock not routed");
    a_nmi_follows: assert property (@(posedge clk) disable iff (!resetn)
        (osc_fault_flag & osc_fault_irq_en) |-> nmi_req || $past(!osc_fault_irq_en))
        else $error("fault flag without interrupt");
    a_nmi_masked: assert property (@(posedge clk) disable iff (!resetn)
        !osc_fault_irq_en |=> !nmi_req)
        else $error("interrupt raised while disabled");
    a_flags_sticky: assert property (@(posedge clk) disable iff (!resetn)
        (crystal_two_fault_flag & !fault_clear) |=> crystal_two_fault_flag)
        else $error("fault flag dropped without clear");
    a_combined_or: assert property (@(posedge clk) disable iff (!resetn)
        osc_fault_flag == (crystal_one_fault_flag | crystal_two_fault_flag | r.osc_fault))
        else $error("combined fault flag wrong");
endmodule
`default_nettype wire
